// >>> verilog/pfrp_top.sv
// Program flash range protection: configuration, status and command check.
// Assumes one AHB-Lite master and one flash command controller on i_clk_sys.
// The controller needs no wait: every request is judged in the cycle it is seen.
// Only whole-word transfers are expected; hsize is not decoded.
// Register map: configuration, status (write one to clear) and interrupt mask.
`timescale 1ns/1ps
module pfrp_top
	import pfrp_pkg::*;
#(
	parameter logic [17:0] FLASH_BASE   = PFRP_FLASH_BASE,   // First byte of the block
	parameter logic [17:0] SECTOR_BYTES = PFRP_SECTOR_BYTES, // Sector size, power of two
	parameter logic [71:0] HIGH_LENS    = PFRP_HIGH_LENS,    // High lengths per code
	parameter logic [71:0] LOW_LENS     = PFRP_LOW_LENS      // Low lengths per code
) (
	input  wire logic        i_clk_sys,   // Bus clock, 40 MHz
	input  wire logic        i_reset,     // Synchronous reset, active high
	// AHB-Lite slave
	input  wire logic        i_hsel,      // Slave select
	input  wire logic [31:0] i_haddr,     // Byte address
	input  wire logic [1:0]  i_htrans,    // Transfer type
	input  wire logic        i_hwrite,    // Write when high
	input  wire logic [2:0]  i_hsize,     // Transfer size, word only
	input  wire logic [31:0] i_hwdata,    // Write data
	input  wire logic        i_hready,    // Bus ready
	output logic      [31:0] o_hrdata,    // Read data
	output logic             o_hreadyout, // Slave ready
	output logic             o_hresp,     // Response, always OKAY
	// Flash command controller
	input  wire logic        i_cmd_valid, // Command request
	input  wire logic [1:0]  i_cmd_op,    // Command kind
	input  wire logic [17:0] i_cmd_addr,  // Global target address
	output logic             o_cmd_ready, // Request taken this cycle
	output logic             o_cmd_grant, // Command may run
	output logic             o_cmd_deny,  // Command refused
	output logic             o_launch_blocked, // No launch while violation stands
	// Interrupt
	output logic             o_irq        // Level, unmasked status set
);

	////////////////////////////////////////////////////////////////////////////////
	// State of the whole block, registered as one word
	// Keeping every flop in one struct gives one reset point and one register process,
	// so no field can miss the reset by accident.
	// grant and deny are pulses; rdata holds until the next read address phase.
	typedef struct packed {
		logic [7:0]  cfg;     // program_flash_protection_config
		logic        viol;    // protection_violation_flag
		logic        done;    // Command granted event
		logic [7:0]  mask;    // Interrupt mask
		logic        wr_pend; // Write data phase is due
		logic [7:0]  wr_addr; // Offset of the pending write
		logic [31:0] rdata;   // Read data of the last read
		logic        grant;   // Grant pulse
		logic        deny;    // Deny pulse
	} pfrp_state_s;

	pfrp_state_s st_q;        // Current state
	pfrp_state_s st_d;        // Next state

	logic [17:0] high_len;    // High region length
	logic [17:0] low_len;     // Low region length
	logic [17:0] span_first;  // First byte touched by the command
	logic [17:0] span_last;   // Last byte touched by the command
	logic        span_prot;   // Span holds a protected byte
	logic        altering;    // Command changes flash contents
	logic        addr_phase;  // Valid address phase this cycle
	logic [7:0]  stat_now;    // Status as it reads
	logic [7:0]  rd_val;      // Register value for a read

	////////////////////////////////////////////////////////////////////////////////
	// Region lengths from the size codes
	// Sizes index a table, so a part with other lengths needs only new parameters
	pfrp_size_lut #(
		.HIGH_LENS   (HIGH_LENS),
		.LOW_LENS    (LOW_LENS)
	) u_lut (
		.i_high_size (st_q.cfg[PFRP_CFG_HS_LO +: 2]),
		.i_low_size  (st_q.cfg[PFRP_CFG_LS_LO +: 2]),
		.o_high_len  (high_len),
		.o_low_len   (low_len)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Span of the request: one byte, one sector or the whole block
	// SECTOR_BYTES must be a power of two, otherwise the alignment mask below is wrong.
	// A block erase always spans the whole block, so any active protected byte refuses it.
	// Limitation: a program is judged on its one address only; wider words are not split.
	// The opcode cast is safe: all four codes have a branch or reach the default.
	always_comb begin
		case (pfrp_op_e'(i_cmd_op))
			PFRP_OP_SECTOR: begin
				// Sector aligned by clearing the offset bits
				span_first = i_cmd_addr & ~(SECTOR_BYTES - 18'h00001);
				span_last  = span_first + SECTOR_BYTES - 18'h00001;
			end
			PFRP_OP_BLOCK: begin
				// Every sector of the block must be free
				span_first = FLASH_BASE;
				span_last  = PFRP_HIGH_END;
			end
			default: begin
				// Program and non-altering commands look at the one address given
				span_first = i_cmd_addr;
				span_last  = i_cmd_addr;
			end
		endcase
		altering = (pfrp_op_e'(i_cmd_op) != PFRP_OP_OTHER);
	end

	// Protection decision for the span; purely combinational, so the verdict
	// is ready in the same cycle as the request and registered below
	pfrp_range_check u_check (
		.i_sense     (st_q.cfg[PFRP_CFG_SENSE]),
		.i_high_dis  (st_q.cfg[PFRP_CFG_HDIS]),
		.i_low_dis   (st_q.cfg[PFRP_CFG_LDIS]),
		.i_high_len  (high_len),
		.i_low_len   (low_len),
		.i_first     (span_first),
		.i_last      (span_last),
		.o_protected (span_prot)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Next state: bus writes first, then command events, then read capture
	always_comb begin
		st_d       = st_q;
		addr_phase = i_hsel & i_htrans[1] & i_hready;
		stat_now   = 8'h00;
		rd_val     = 8'h00;

		// Pulses last one cycle
		// A pulse never stretches: each request gets exactly one answer
		st_d.grant = 1'b0;
		st_d.deny  = 1'b0;

		// Write data phase
		if (st_q.wr_pend) begin
			case (st_q.wr_addr)
				PFRP_REG_CFG: begin
					// Bit six is stored as written; keeping it erased is up to software
					st_d.cfg[PFRP_CFG_SENSE] = i_hwdata[PFRP_CFG_SENSE];
					st_d.cfg[PFRP_CFG_RESV]  = i_hwdata[PFRP_CFG_RESV];
					st_d.cfg[PFRP_CFG_HDIS]  = i_hwdata[PFRP_CFG_HDIS];
					st_d.cfg[PFRP_CFG_LDIS]  = i_hwdata[PFRP_CFG_LDIS];
					// Sizes change only while their range is off, judged before this write
					if (st_q.cfg[PFRP_CFG_HDIS]) begin
						st_d.cfg[PFRP_CFG_HS_LO +: 2] = i_hwdata[PFRP_CFG_HS_LO +: 2];
					end
					if (st_q.cfg[PFRP_CFG_LDIS]) begin
						st_d.cfg[PFRP_CFG_LS_LO +: 2] = i_hwdata[PFRP_CFG_LS_LO +: 2];
					end
				end
				PFRP_REG_STAT: begin
					// Write one clears, zero leaves alone
					// The done bit clears the same way; it feeds only the interrupt and the status read
					if (i_hwdata[PFRP_STAT_VIOL]) begin
						st_d.viol = 1'b0;
					end
					if (i_hwdata[PFRP_STAT_DONE]) begin
						st_d.done = 1'b0;
					end
				end
				PFRP_REG_MASK: begin
					// Only the two event bits exist; the rest read zero
					st_d.mask[PFRP_STAT_VIOL] = i_hwdata[PFRP_STAT_VIOL];
					st_d.mask[PFRP_STAT_DONE] = i_hwdata[PFRP_STAT_DONE];
				end
				default: begin
					// Unmapped write is dropped, still OKAY
				end
			endcase
		end

		// A clear and a new violation in one cycle leave the flag set only if it was clear before; while it stands,
		// a protected command is only refused, not flagged, so clearing the old event in that cycle drops the flag
		// Command check; placed after the clear so a same-cycle event wins
		if (i_cmd_valid) begin
			if (st_q.viol) begin
				// Standing violation refuses every launch
				st_d.deny = 1'b1;
			end else if (altering && span_prot) begin
				st_d.deny = 1'b1;
				st_d.viol = 1'b1;
			end else begin
				st_d.grant = 1'b1;
				st_d.done  = 1'b1;
			end
		end

		// Address phase capture
		// Only the low byte of the address is decoded; the map repeats every 256 bytes
		st_d.wr_pend = addr_phase & i_hwrite;
		if (addr_phase) begin
			st_d.wr_addr = i_haddr[7:0];
		end

		// Reads see the state after any write in this cycle
		// Taking st_d here lets a read right after a write return the new value
		// without a wait state; the price is a longer path from hwdata to rdata
		stat_now[PFRP_STAT_VIOL] = st_d.viol;
		stat_now[PFRP_STAT_DONE] = st_d.done;
		case (i_haddr[7:0])
			PFRP_REG_CFG:  rd_val = st_d.cfg;
			PFRP_REG_STAT: rd_val = stat_now;
			PFRP_REG_MASK: rd_val = st_d.mask;
			default:       rd_val = 8'h00; // Unmapped reads as zero
		endcase
		if (addr_phase && !i_hwrite) begin
			st_d.rdata = {24'h000000, rd_val};
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// State register with synchronous reset
	// Reset loads the erased configuration: sense one with both ranges off, no protection
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			st_q         <= '0;
			st_q.cfg     <= PFRP_CFG_RESET;
			st_q.mask    <= PFRP_MASK_RESET;
		end else begin
			st_q         <= st_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Outputs; the slave never inserts wait states, so ready is constant
	// All data outputs come straight from flops; only constants and the irq OR are gates
	// hresp is tied low: every transfer, mapped or not, ends OKAY
	always_comb begin
		o_hrdata         = st_q.rdata;
		o_hreadyout      = 1'b1;
		o_hresp          = 1'b0;
		o_cmd_ready      = 1'b1;  // Every request is judged in one cycle
		o_cmd_grant      = st_q.grant;
		o_cmd_deny       = st_q.deny;
		o_launch_blocked = st_q.viol;
		o_irq            = (st_q.viol & st_q.mask[PFRP_STAT_VIOL]) |
		                   (st_q.done & st_q.mask[PFRP_STAT_DONE]);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks on the decisions taken above
	// Every check samples on the bus clock and is muted while reset stands,
	// so the unknown state before the first reset edge cannot fire anything
	// Antecedents that read st_q look at the state the request was judged against
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	// Data phase of a configuration write; the size checks key off it
	logic cfg_wr; // Configuration data phase
	assign cfg_wr = st_q.wr_pend && (st_q.wr_addr == PFRP_REG_CFG);

	a_prot_denies: assert property (i_cmd_valid && !st_q.viol && altering && span_prot
		|=> o_cmd_deny && !o_cmd_grant && o_launch_blocked)
		else $error("protected command not refused with flag");

	a_block_refuse: assert property (i_cmd_valid && i_cmd_op == PFRP_OP_BLOCK
		&& st_q.cfg[PFRP_CFG_SENSE] && !st_q.cfg[PFRP_CFG_LDIS] |=> o_cmd_deny)
		else $error("block erase granted over protected low range");

	a_open_grant: assert property (i_cmd_valid && !st_q.viol && st_q.cfg[PFRP_CFG_SENSE]
		&& st_q.cfg[PFRP_CFG_HDIS] && st_q.cfg[PFRP_CFG_LDIS] |=> o_cmd_grant && !o_cmd_deny)
		else $error("unprotected command not granted");

	a_full_lock: assert property (i_cmd_valid && altering && !st_q.cfg[PFRP_CFG_SENSE]
		&& st_q.cfg[PFRP_CFG_HDIS] && st_q.cfg[PFRP_CFG_LDIS] |=> o_cmd_deny)
		else $error("fully protected flash accepted a change");

	a_sense_flip: assert property (i_cmd_valid && altering && !st_q.viol
		&& st_q.cfg[PFRP_CFG_HDIS] && !st_q.cfg[PFRP_CFG_LDIS]
		&& i_cmd_op == PFRP_OP_PROGRAM && i_cmd_addr == PFRP_LOW_BEGIN
		|=> (o_cmd_deny == $past(st_q.cfg[PFRP_CFG_SENSE])))
		else $error("sense bit not reversing low range meaning");

	a_high_top: assert property (i_cmd_valid && st_q.cfg[PFRP_CFG_SENSE]
		&& !st_q.cfg[PFRP_CFG_HDIS] && i_cmd_op == PFRP_OP_PROGRAM && i_cmd_addr == PFRP_HIGH_END
		|=> o_cmd_deny)
		else $error("top address not in high protected range");

	a_low_base: assert property (i_cmd_valid && st_q.cfg[PFRP_CFG_SENSE]
		&& !st_q.cfg[PFRP_CFG_LDIS] && i_cmd_op == PFRP_OP_PROGRAM && i_cmd_addr == PFRP_LOW_BEGIN
		|=> o_cmd_deny)
		else $error("low base address not in low protected range");

	a_hsize_hold: assert property (cfg_wr && !st_q.cfg[PFRP_CFG_HDIS]
		|=> st_q.cfg[PFRP_CFG_HS_LO +: 2] == $past(st_q.cfg[PFRP_CFG_HS_LO +: 2]))
		else $error("high size changed while range enabled");

	a_lsize_hold: assert property (cfg_wr && !st_q.cfg[PFRP_CFG_LDIS]
		|=> st_q.cfg[PFRP_CFG_LS_LO +: 2] == $past(st_q.cfg[PFRP_CFG_LS_LO +: 2]))
		else $error("low size changed while range enabled");

	a_viol_blocks: assert property (st_q.viol && i_cmd_valid
		|=> o_cmd_deny && !o_cmd_grant)
		else $error("command launched while violation stands");

	a_viol_clear: assert property (st_q.viol && st_q.wr_pend && st_q.wr_addr == PFRP_REG_STAT
		&& i_hwdata[PFRP_STAT_VIOL] && !i_cmd_valid |=> !o_launch_blocked)
		else $error("write one did not clear violation");

	////////////////////////////////////////////////////////////////////////////////
	// Checks on pulse shape, stickiness, non-altering commands and size loading

	a_pulse_once: assert property (!i_cmd_valid
		|=> !o_cmd_grant && !o_cmd_deny)
		else $error("answer pulse without a request");

	a_viol_sticky: assert property (st_q.viol
		&& !(st_q.wr_pend && st_q.wr_addr == PFRP_REG_STAT && i_hwdata[PFRP_STAT_VIOL])
		|=> o_launch_blocked)
		else $error("violation flag dropped without a clear");

	a_other_pass: assert property (i_cmd_valid && i_cmd_op == PFRP_OP_OTHER && !st_q.viol
		|=> o_cmd_grant && !o_launch_blocked)
		else $error("non-altering command refused or flagged");

	a_hsize_load: assert property (cfg_wr && st_q.cfg[PFRP_CFG_HDIS]
		|=> st_q.cfg[PFRP_CFG_HS_LO +: 2] == $past(i_hwdata[PFRP_CFG_HS_LO +: 2]))
		else $error("high size write lost while range off");

	a_lsize_load: assert property (cfg_wr && st_q.cfg[PFRP_CFG_LDIS]
		|=> st_q.cfg[PFRP_CFG_LS_LO +: 2] == $past(i_hwdata[PFRP_CFG_LS_LO +: 2]))
		else $error("low size write lost while range off");

	// Main scenarios reached by the bench
	c_grant:      cover property (i_cmd_valid ##1 o_cmd_grant);
	c_block_deny: cover property (i_cmd_valid && i_cmd_op == PFRP_OP_BLOCK ##1 o_cmd_deny);
	c_viol_clear: cover property (o_launch_blocked ##[1:20] !o_launch_blocked);
	c_irq:        cover property (o_irq);
	c_sense_open: cover property (i_cmd_valid && !st_q.cfg[PFRP_CFG_SENSE] ##1 o_cmd_grant);

endmodule

// >>> pkg/pfrp_pkg.sv
// Shared constants for the program flash range protection block.
// Assumes an 18-bit global flash address and a 32-bit AHB-Lite register bus.
package pfrp_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Address geometry
	localparam int          PFRP_AW           = 18;        // Global flash address width
	localparam logic [17:0] PFRP_HIGH_END     = 18'h3ffff; // High region always ends here
	localparam logic [17:0] PFRP_LOW_BEGIN    = 18'h38000; // Low region always starts here
	localparam logic [17:0] PFRP_FLASH_BASE   = 18'h34000; // First byte of the flash block
	localparam logic [17:0] PFRP_SECTOR_BYTES = 18'h00200; // Sector length in bytes

	// Default region lengths per size code, entry 0 in the low bits
	localparam logic [71:0] PFRP_HIGH_LENS = {18'h04000, 18'h02000, 18'h01000, 18'h00800};
	localparam logic [71:0] PFRP_LOW_LENS  = {18'h04000, 18'h02000, 18'h01000, 18'h00800};

	////////////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] PFRP_REG_CFG  = 8'h00; // Protection configuration
	localparam logic [7:0] PFRP_REG_STAT = 8'h04; // Flash status, write one to clear
	localparam logic [7:0] PFRP_REG_MASK = 8'h08; // Interrupt mask, same layout as status

	// Configuration field positions
	localparam int PFRP_CFG_SENSE = 7; // protection_sense_select
	localparam int PFRP_CFG_RESV  = 6; // reserved_nonvolatile_bit
	localparam int PFRP_CFG_HDIS  = 5; // high_range_disable
	localparam int PFRP_CFG_HS_LO = 3; // high_range_size low bit
	localparam int PFRP_CFG_LDIS  = 2; // low_range_disable
	localparam int PFRP_CFG_LS_LO = 0; // low_range_size low bit

	// Status field positions
	localparam int PFRP_STAT_DONE = 7; // A command was granted
	localparam int PFRP_STAT_VIOL = 4; // protection_violation_flag

	// Reset values: erased configuration means no protection
	localparam logic [7:0] PFRP_CFG_RESET  = 8'hff;
	localparam logic [7:0] PFRP_MASK_RESET = 8'h00;

	////////////////////////////////////////////////////////////////////////////////
	// Commands from the flash command controller
	typedef enum logic [1:0] {
		PFRP_OP_PROGRAM = 2'b00, // Program at one address
		PFRP_OP_SECTOR  = 2'b01, // Erase the sector holding the address
		PFRP_OP_BLOCK   = 2'b10, // Erase the whole flash block
		PFRP_OP_OTHER   = 2'b11  // Non-altering command
	} pfrp_op_e;

endpackage

// >>> verilog/pfrp_size_lut.sv
// Lookup of region lengths from the two-bit size codes.
// Assumes codes come from configuration flops on the same clock.
`timescale 1ns/1ps
module pfrp_size_lut
	import pfrp_pkg::*;
#(
	parameter logic [71:0] HIGH_LENS = PFRP_HIGH_LENS, // Four 18-bit lengths
	parameter logic [71:0] LOW_LENS  = PFRP_LOW_LENS   // Four 18-bit lengths
) (
	input  wire logic [1:0]  i_high_size, // high_range_size code
	input  wire logic [1:0]  i_low_size,  // low_range_size code
	output logic      [17:0] o_high_len,  // High region length in bytes
	output logic      [17:0] o_low_len    // Low region length in bytes
);

	////////////////////////////////////////////////////////////////////////////////
	// Table select; the tables are parameters since sizes may differ per part
	always_comb begin
		o_high_len = HIGH_LENS[i_high_size*PFRP_AW +: PFRP_AW];
		o_low_len  = LOW_LENS[i_low_size*PFRP_AW +: PFRP_AW];
	end

endmodule

// >>> verilog/pfrp_range_check.sv
// Decides whether any byte of an address span is protected.
// Assumes span first <= last and both lie inside the flash block.
`timescale 1ns/1ps
module pfrp_range_check
	import pfrp_pkg::*;
(
	input  wire logic        i_sense,    // protection_sense_select
	input  wire logic        i_high_dis, // high_range_disable
	input  wire logic        i_low_dis,  // low_range_disable
	input  wire logic [17:0] i_high_len, // High region length
	input  wire logic [17:0] i_low_len,  // Low region length
	input  wire logic [17:0] i_first,    // First byte of the span
	input  wire logic [17:0] i_last,     // Last byte of the span
	output logic             o_protected // Some byte of the span is protected
);

	logic [17:0] hi_start;    // First byte of the high region
	logic [17:0] lo_last;     // Last byte of the low region
	logic        hi_en;       // High region active
	logic        lo_en;       // Low region active
	logic        over_hi;     // Span touches the high region
	logic        over_lo;     // Span touches the low region
	logic        in_hi;       // Span lies wholly in the high region
	logic        in_lo;       // Span lies wholly in the low region
	logic        in_union;    // Span lies in the joined regions

	////////////////////////////////////////////////////////////////////////////////
	// Region bounds and span relations
	always_comb begin
		hi_start = PFRP_HIGH_END - i_high_len + 18'h00001;
		lo_last  = PFRP_LOW_BEGIN + i_low_len - 18'h00001;
		hi_en    = ~i_high_dis;
		lo_en    = ~i_low_dis;
		over_hi  = hi_en & (i_last >= hi_start);
		over_lo  = lo_en & (i_first <= lo_last) & (i_last >= PFRP_LOW_BEGIN);
		in_hi    = hi_en & (i_first >= hi_start);
		in_lo    = lo_en & (i_first >= PFRP_LOW_BEGIN) & (i_last <= lo_last);
		// Regions may meet; a span bridging them is still wholly covered
		in_union = hi_en & lo_en & (i_first >= PFRP_LOW_BEGIN) &
		           ({1'b0, lo_last} + 19'h00001 >= {1'b0, hi_start});
		// Sense 1 marks protected ranges, sense 0 marks open ranges
		if (i_sense) begin
			o_protected = over_hi | over_lo;
		end else begin
			o_protected = ~(in_hi | in_lo | in_union);
		end
	end

endmodule

// >>> dv/pfrp_cmd_model.sv
// Partner model: the flash command controller that issues program and erase requests.
// Assumes the checker answers one edge after the request edge, on a free-running i_clk.
`timescale 1ns/1ps
module pfrp_cmd_model
	import pfrp_pkg::*;
(
	input  wire logic        i_clk,   // Bus clock
	input  wire logic        i_grant, // Command allowed pulse
	input  wire logic        i_deny,  // Command refused pulse
	output logic             o_valid, // Request strobe
	output logic      [1:0]  o_op,    // Command kind
	output logic      [17:0] o_addr   // Global target address
);
	// Quiet outputs from time zero
	initial begin
		o_valid = 1'b0;
		o_op    = PFRP_OP_OTHER;
		o_addr  = 18'h00000;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One request: held for one edge, the answer read once that edge has landed
	// No launch gate here: the bench asks for a launch while blocked on purpose
	task automatic issue(input logic [1:0] op, input logic [17:0] addr, output logic [1:0] ans);
		@(posedge i_clk);
		o_valid <= 1'b1;
		o_op    <= op;
		o_addr  <= addr;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_addr  <= ~addr; // Released address must not look valid
		#1;
		ans = {i_grant, i_deny};
	endtask
endmodule

// >>> dv/testbench.sv
// Self-checking bench for the program flash range protection block.
// Assumes one AHB-Lite master here and the command controller model beside it.
`timescale 1ns/1ps
module testbench;
	import pfrp_pkg::*;
	logic        clk = 1'b0;      // 40 MHz bus clock
	logic        rst = 1'b1;      // Synchronous reset
	logic        hsel = 1'b0;     // Slave select
	logic [31:0] haddr = '0;      // Byte address
	logic [1:0]  htrans = 2'b00;  // Transfer type
	logic        hwrite = 1'b0;   // Write flag
	logic [31:0] hwdata = '0;     // Write data
	logic [31:0] hrdata;          // Read data
	logic        hready;          // Slave ready fed back
	logic        hresp;           // Response
	logic        cvalid;          // Command strobe
	logic [1:0]  cop;             // Command kind
	logic [17:0] caddr;           // Command address
	logic        grant;           // Allowed pulse
	logic        deny;            // Refused pulse
	logic        blocked;         // Launch blocked level
	logic        irq;             // Interrupt level
	logic        cready;          // Request taken level
	int          bad_count = 0;   // Mismatches
	int          compares = 0;    // Comparisons
	int          cycles = 0;      // Timeout counter
	logic [1:0]  ans;             // Model answer

	always #12.5 clk = ~clk;

	pfrp_top u_dut (.i_clk_sys(clk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hwrite(hwrite), .i_hsize(3'b010), .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata),
		.o_hreadyout(hready), .o_hresp(hresp), .i_cmd_valid(cvalid), .i_cmd_op(cop), .i_cmd_addr(caddr),
		.o_cmd_ready(cready), .o_cmd_grant(grant), .o_cmd_deny(deny), .o_launch_blocked(blocked), .o_irq(irq));

	pfrp_cmd_model u_model (.i_clk(clk), .i_grant(grant), .i_deny(deny), .o_valid(cvalid), .o_op(cop),
		.o_addr(caddr));

	////////////////////////////////////////////////////////////////////////////////
	// Shared tasks
	task automatic results();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Single AHB-Lite word transfer; waits on hready, no fixed latency assumed
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk);
		hsel   <= 1'b1;
		htrans <= 2'b10;
		haddr  <= {24'h000000, a};
		hwrite <= wr;
		do @(posedge clk); while (hready !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wr ? wd : 32'hffffffff;
		do @(posedge clk); while (hready !== 1'b1);
		rd = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] unused;
		bus(1'b1, a, d, unused);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 32'h0, rd);
		chk(rd, exp);
	endtask

	// Command with expected outcome; a refusal or grant is cleared afterwards
	task automatic cmd(input logic [1:0] op, input logic [17:0] a, input logic prot);
		u_model.issue(op, a, ans);
		chk({30'h0, ans}, prot ? 32'h1 : 32'h2);
		wr(8'h04, 32'h90);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		rdc(8'h00, 32'hff);
		rdc(8'h04, 32'h0);
		rdc(8'h08, 32'h0);
		rdc(8'h0c, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		chk({31'h0, cready}, 32'h1);
		$display("test reset done");
	endtask

	// Size fields move only while their disable bit was already set
	task automatic t_size();
		wr(8'h00, 32'h40);
		rdc(8'h00, 32'h40);
		wr(8'h00, 32'h5b);
		rdc(8'h00, 32'h40);
		wr(8'h00, 32'hff);
		rdc(8'h00, 32'he4);
		$display("test size done");
	endtask

	// All eight sense and disable codes, probed at region edges with the smallest sizes
	task automatic t_decode();
		logic s;
		logic h;
		logic l;
		for (int i = 0; i < 8; i++) begin
			s = i[2];
			h = i[1];
			l = i[0];
			wr(8'h00, {24'h0, s, 1'b1, h, 2'b00, l, 2'b00});
			cmd(PFRP_OP_PROGRAM, 18'h3f800, s ^ h);
			cmd(PFRP_OP_PROGRAM, 18'h387ff, s ^ l);
			cmd(PFRP_OP_PROGRAM, 18'h3f7ff, !s);
			cmd(PFRP_OP_PROGRAM, PFRP_LOW_BEGIN, s ^ l);
		end
		$display("test decode done");
	endtask

	// Violation flag, launch block, write-one-clear and interrupt masking
	task automatic t_viol();
		wr(8'h08, 32'h10);
		wr(8'h00, 32'hc4);
		u_model.issue(PFRP_OP_PROGRAM, 18'h3ffff, ans);
		chk({30'h0, ans}, 32'h1);
		chk({31'h0, blocked}, 32'h1);
		rdc(8'h04, 32'h10);
		chk({31'h0, irq}, 32'h1);
		u_model.issue(PFRP_OP_PROGRAM, 18'h34000, ans);
		chk({30'h0, ans}, 32'h1);
		wr(8'h04, 32'h0);
		rdc(8'h04, 32'h10);
		wr(8'h08, 32'h0);
		rdc(8'h08, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h04, 32'h10);
		rdc(8'h04, 32'h0);
		chk({31'h0, blocked}, 32'h0);
		u_model.issue(PFRP_OP_PROGRAM, 18'h34000, ans);
		chk({30'h0, ans}, 32'h2);
		wr(8'h08, 32'h80);
		rdc(8'h04, 32'h80);
		chk({31'h0, irq}, 32'h1);
		wr(8'h04, 32'h80);
		rdc(8'h04, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wr(8'h08, 32'h0);
		$display("test violation done");
	endtask

	// Erase kinds against a protected low range, then with protection off
	task automatic t_block();
		wr(8'h00, 32'he0);
		cmd(PFRP_OP_BLOCK, 18'h34000, 1'b1);
		cmd(PFRP_OP_SECTOR, 18'h34000, 1'b0);
		cmd(PFRP_OP_SECTOR, 18'h38600, 1'b1);
		cmd(PFRP_OP_SECTOR, 18'h38800, 1'b0);
		cmd(PFRP_OP_OTHER, 18'h38000, 1'b0);
		wr(8'h00, 32'hff);
		rdc(8'h00, 32'hfc);
		cmd(PFRP_OP_BLOCK, 18'h3ffff, 1'b0);
		$display("test block done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence and hang guard
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			$display("[FAIL] %0t timeout", $time);
			results();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset();
		t_size();
		t_decode();
		t_viol();
		t_block();
		results();
	end
endmodule
